// >>> rtl/pecs_pkg.sv
`default_nettype none
package pecs_pkg;
  // ***************************************************
  // register addresses on the management bus
  // ***************************************************
  localparam logic [4:0] REG_LP_NP     = 5'h08;
  localparam logic [4:0] REG_RSV_LO    = 5'h09;
  localparam logic [4:0] REG_RSV_HI    = 5'h0F;
  localparam logic [4:0] REG_EXT_CTRL  = 5'h10;
  localparam logic [4:0] REG_QP_STAT   = 5'h11;

  // ***************************************************
  // field positions
  // ***************************************************
  localparam int LP_CODE_HI      = 3;
  localparam int EXT_CMD_OVR     = 15;
  localparam int EXT_PHYAD_HI    = 10;
  localparam int EXT_PHYAD_LO    = 6;
  localparam int EXT_CIPH_TEST   = 5;
  localparam int EXT_NRZI        = 3;
  localparam int EXT_TX_INVALID  = 2;
  localparam int EXT_CIPH_BYPASS = 0;
  localparam int QP_SPEED        = 15;
  localparam int QP_DUPLEX       = 14;
  localparam int QP_PROG_HI      = 13;
  localparam int QP_PROG_LO      = 11;

  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [15:0] LP_NP_RST       = 16'h0000;
  localparam logic        CMD_OVR_RST     = 1'b0;
  localparam logic        CIPH_TEST_RST   = 1'b0;
  localparam logic        NRZI_RST        = 1'b1;
  localparam logic        TX_INVALID_RST  = 1'b0;
  localparam logic        CIPH_BYPASS_RST = 1'b0;
  localparam logic [2:0]  PROG_RST        = 3'h0;
  localparam logic        PHYAD_MSB_VAL   = 1'b1;
  localparam logic [3:0]  STRAP_RST       = 4'h0;

  // ***************************************************
  // serial management frame
  // ***************************************************
  localparam int         PRE_LEN  = 32;
  localparam int         HDR_BITS = 12;
  localparam int         DATA_BITS = 16;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_HDR,
    ST_TA,
    ST_DATA
  } pecs_frame_state_t;
endpackage : pecs_pkg
`default_nettype wire

// >>> rtl/pecs_mgmt_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pecs_mgmt_if;
  logic        rd_stb;    // one-cycle read request
  logic        wr_stb;    // one-cycle write request
  logic [4:0]  addr;      // register address
  logic [15:0] wdata;     // write data
  logic [15:0] rd_data;   // read data for addr
  logic [4:0]  phy_addr;  // own management address

  modport engine (output rd_stb, output wr_stb, output addr, output wdata,
                  input rd_data, input phy_addr);
  modport regs   (input rd_stb, input wr_stb, input addr, input wdata,
                  output rd_data, output phy_addr);
endinterface : pecs_mgmt_if
`default_nettype wire

// >>> rtl/pecs_mdio_engine.sv
`timescale 1ns/1ns
`default_nettype none
module pecs_mdio_engine (
  input  wire logic  clock,      // system clock
  input  wire logic  sys_rst,    // async reset, active high
  input  wire logic  mdc_pin,    // management clock pin
  input  wire logic  mdio_in,    // management data pin level
  output var  logic  mdio_out,   // management data driven value
  output var  logic  mdio_oe_n,  // low while driving
  pecs_mgmt_if.engine mif        // register side
);
  logic [2:0]  mdc_sync;
  logic [1:0]  mdio_sync;
  logic        mdc_rise;
  logic        bit_in;
  pecs_pkg::pecs_frame_state_t state;
  logic [5:0]  pre_cnt;
  logic [4:0]  cnt;
  logic [11:0] hdr;
  logic [11:0] next_hdr;
  logic        is_read;
  logic [15:0] shreg;

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  // mdc is far slower than clock, so edge detect on the synced copy is safe
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mdc_sync  <= 3'h0;
      mdio_sync <= 2'h3;
    end else begin
      mdc_sync  <= {mdc_sync[1:0], mdc_pin};
      mdio_sync <= {mdio_sync[0], mdio_in};
    end
  end
  assign mdc_rise = mdc_sync[1] & ~mdc_sync[2];
  assign bit_in   = mdio_sync[1];
  assign next_hdr = {hdr[10:0], bit_in};

  // ***************************************************
  // frame sequencer
  // ***************************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= pecs_pkg::ST_IDLE;
      pre_cnt    <= 6'h00;
      cnt        <= 5'h00;
      hdr        <= 12'h000;
      is_read    <= 1'b0;
      shreg      <= 16'h0000;
      mdio_out   <= 1'b1;
      mdio_oe_n  <= 1'b1;
      mif.rd_stb <= 1'b0;
      mif.wr_stb <= 1'b0;
      mif.addr   <= 5'h00;
      mif.wdata  <= 16'h0000;
    end else begin
      mif.rd_stb <= 1'b0;
      mif.wr_stb <= 1'b0;
      // read data is valid in the cycle the request stands
      if (mif.rd_stb)
        shreg <= mif.rd_data;
      if (mdc_rise) begin
        case (state)
          pecs_pkg::ST_IDLE: begin
            if (bit_in) begin
              if (pre_cnt != 6'(pecs_pkg::PRE_LEN))
                pre_cnt <= pre_cnt + 6'h01;
            end else if (pre_cnt == 6'(pecs_pkg::PRE_LEN)) begin
              state <= pecs_pkg::ST_START;
            end else begin
              pre_cnt <= 6'h00;
            end
          end
          pecs_pkg::ST_START: begin
            pre_cnt <= 6'h00;
            cnt     <= 5'h00;
            state   <= bit_in ? pecs_pkg::ST_HDR : pecs_pkg::ST_IDLE;
          end
          pecs_pkg::ST_HDR: begin
            hdr <= next_hdr;
            cnt <= cnt + 5'h01;
            if (cnt == 5'(pecs_pkg::HDR_BITS - 1)) begin
              cnt      <= 5'h00;
              mif.addr <= next_hdr[4:0];
              is_read  <= (next_hdr[11:10] == pecs_pkg::OP_READ);
              if (next_hdr[9:5] != mif.phy_addr ||
                  (next_hdr[11:10] != pecs_pkg::OP_READ &&
                   next_hdr[11:10] != pecs_pkg::OP_WRITE)) begin
                state <= pecs_pkg::ST_IDLE;
              end else begin
                state      <= pecs_pkg::ST_TA;
                mif.rd_stb <= (next_hdr[11:10] == pecs_pkg::OP_READ);
              end
            end
          end
          pecs_pkg::ST_TA: begin
            // read: first turnaround bit released, second driven low
            if (is_read) begin
              mdio_oe_n <= 1'b0;
              mdio_out  <= 1'b0;
              state     <= pecs_pkg::ST_DATA;
            end else begin
              cnt <= cnt + 5'h01;
              if (cnt == 5'h01) begin
                cnt   <= 5'h00;
                state <= pecs_pkg::ST_DATA;
              end
            end
          end
          pecs_pkg::ST_DATA: begin
            if (is_read) begin
              if (cnt == 5'(pecs_pkg::DATA_BITS)) begin
                mdio_oe_n <= 1'b1;
                mdio_out  <= 1'b1;
                cnt       <= 5'h00;
                state     <= pecs_pkg::ST_IDLE;
              end else begin
                mdio_out <= shreg[15];
                shreg    <= {shreg[14:0], 1'b0};
                cnt      <= cnt + 5'h01;
              end
            end else begin
              shreg <= {shreg[14:0], bit_in};
              cnt   <= cnt + 5'h01;
              if (cnt == 5'(pecs_pkg::DATA_BITS - 1)) begin
                mif.wdata  <= {shreg[14:0], bit_in};
                mif.wr_stb <= 1'b1;
                cnt        <= 5'h00;
                state      <= pecs_pkg::ST_IDLE;
              end
            end
          end
          default: state <= pecs_pkg::ST_IDLE;
        endcase
      end
    end
  end
endmodule : pecs_mdio_engine
`default_nettype wire

// >>> rtl/pecs_regs.sv
// Function
// - partner next-page code bits 3:0 read-only, hold received code, reset zero
// - addresses nine to fifteen reserved, no vendor function behind them
// - control bit 15 command-override write enable, self clearing, resets zero
// - control bit 5 sets stream cipher test mode, resets zero
// - control bit 2 enables sending invalid code groups, resets zero
// - control bit 0 bypasses stream cipher scrambler, resets zero
// - status bit 15 reads speed: zero 10 Mbps, one 100 Mbps
// - status bits 13:12 progress monitor, latching maximum, reset zero
// - status bit 11 lowest progress bit, same latching maximum and reset
`timescale 1ns/1ns
`default_nettype none
module pecs_regs (
  input  wire logic        clock,            // 125 MHz system clock
  input  wire logic        sys_rst,          // async reset, active high
  input  wire logic        mdc,              // management clock pin
  input  wire logic        mdio_in,          // management data pin input
  output var  logic        mdio_out,         // management data pin output
  output var  logic        mdio_oe_n,        // management data enable, low drives
  input  wire logic [3:0]  phyad_strap,      // address strap pins, bits 3:0
  input  wire logic [15:0] lp_np_word,       // received partner next-page word
  input  wire logic        lp_np_load,       // pulse: new partner page received
  input  wire logic        speed_100,        // resolved rate, high for 100 Mbps
  input  wire logic        full_duplex,      // resolved duplex, high for full
  input  wire logic [2:0]  an_progress,      // current negotiation progress code
  output var  logic        cmd_override_en,  // command-override write enable
  output var  logic        cipher_test_mode, // stream cipher test mode
  output var  logic        nrzi_select,      // high NRZI, low NRZ
  output var  logic        tx_invalid_en,    // allow invalid code groups
  output var  logic        cipher_bypass     // scrambler bypassed
);
  pecs_mgmt_if mif ();

  logic [3:0]  strap_q1;
  logic [3:0]  strap_q2;
  logic [1:0]  strap_wait;
  logic [3:0]  strap_val;
  logic [15:0] lp_np;
  logic [2:0]  prog_max;
  logic [15:0] ext_word;
  logic [15:0] qp_word;
  logic        wr_ext;
  logic        rd_qp;

  pecs_mdio_engine u_engine (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .mdc_pin   (mdc),
    .mdio_in   (mdio_in),
    .mdio_out  (mdio_out),
    .mdio_oe_n (mdio_oe_n),
    .mif       (mif.engine)
  );

  // ***************************************************
  // strap capture after reset release
  // ***************************************************
  // straps are pins: synchronise, then freeze once the chain has settled
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      strap_q1 <= pecs_pkg::STRAP_RST;
      strap_q2 <= pecs_pkg::STRAP_RST;
    end else begin
      strap_q1 <= phyad_strap;
      strap_q2 <= strap_q1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      strap_wait <= 2'h0;
      strap_val  <= pecs_pkg::STRAP_RST;
    end else if (strap_wait != 2'h3) begin
      strap_wait <= strap_wait + 2'h1;
      if (strap_wait == 2'h2)
        strap_val <= strap_q2;
    end
  end

  assign mif.phy_addr = {pecs_pkg::PHYAD_MSB_VAL, strap_val};

  // ***************************************************
  // partner next-page word
  // ***************************************************
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      lp_np <= pecs_pkg::LP_NP_RST;
    else if (lp_np_load)
      lp_np <= lp_np_word;
  end

  // ***************************************************
  // extended control
  // ***************************************************
  assign wr_ext = mif.wr_stb && (mif.addr == pecs_pkg::REG_EXT_CTRL);

  // override enable lasts until the next management write has used it
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      cmd_override_en <= pecs_pkg::CMD_OVR_RST;
    else if (wr_ext && mif.wdata[pecs_pkg::EXT_CMD_OVR])
      cmd_override_en <= 1'b1;
    else if (mif.wr_stb)
      cmd_override_en <= 1'b0;
  end

  // reserved bits are not stored: software writes zero to them anyway
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cipher_test_mode <= pecs_pkg::CIPH_TEST_RST;
      nrzi_select      <= pecs_pkg::NRZI_RST;
      tx_invalid_en    <= pecs_pkg::TX_INVALID_RST;
      cipher_bypass    <= pecs_pkg::CIPH_BYPASS_RST;
    end else if (wr_ext) begin
      cipher_test_mode <= mif.wdata[pecs_pkg::EXT_CIPH_TEST];
      nrzi_select      <= mif.wdata[pecs_pkg::EXT_NRZI];
      tx_invalid_en    <= mif.wdata[pecs_pkg::EXT_TX_INVALID];
      cipher_bypass    <= mif.wdata[pecs_pkg::EXT_CIPH_BYPASS];
    end
  end

  // ***************************************************
  // quick-poll progress, latching maximum
  // ***************************************************
  assign rd_qp = mif.rd_stb && (mif.addr == pecs_pkg::REG_QP_STAT);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      prog_max <= pecs_pkg::PROG_RST;
    else if (rd_qp)
      prog_max <= an_progress;
    else if (an_progress > prog_max)
      prog_max <= an_progress;
  end

  // ***************************************************
  // read decode
  // ***************************************************
  always_comb begin
    ext_word = 16'h0000;
    ext_word[pecs_pkg::EXT_CMD_OVR] = cmd_override_en;
    ext_word[pecs_pkg::EXT_PHYAD_HI:pecs_pkg::EXT_PHYAD_LO] = mif.phy_addr;
    ext_word[pecs_pkg::EXT_CIPH_TEST] = cipher_test_mode;
    ext_word[pecs_pkg::EXT_NRZI] = nrzi_select;
    ext_word[pecs_pkg::EXT_TX_INVALID] = tx_invalid_en;
    ext_word[pecs_pkg::EXT_CIPH_BYPASS] = cipher_bypass;
  end

  always_comb begin
    qp_word = 16'h0000;
    qp_word[pecs_pkg::QP_SPEED] = speed_100;
    qp_word[pecs_pkg::QP_DUPLEX] = full_duplex;
    qp_word[pecs_pkg::QP_PROG_HI:pecs_pkg::QP_PROG_LO] = prog_max;
  end

  always_comb begin
    mif.rd_data = 16'h0000;
    if (mif.addr == pecs_pkg::REG_LP_NP)
      mif.rd_data = lp_np;
    else if (mif.addr >= pecs_pkg::REG_RSV_LO && mif.addr <= pecs_pkg::REG_RSV_HI)
      mif.rd_data = 16'h0000;
    else if (mif.addr == pecs_pkg::REG_EXT_CTRL)
      mif.rd_data = ext_word;
    else if (mif.addr == pecs_pkg::REG_QP_STAT)
      mif.rd_data = qp_word;
  end
endmodule : pecs_regs
`default_nettype wire

// >>> verif/pecs_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pecs_regs_checker (
  input  wire logic clock,            // system clock
  input  wire logic sys_rst,          // async reset, active high
  input  wire logic mdc,              // management clock pin
  input  wire logic mdio_out,         // data pin value
  input  wire logic mdio_oe_n,        // data pin enable, low drives
  input  wire logic cmd_override_en,  // override write enable
  input  wire logic cipher_test_mode, // cipher test mode
  input  wire logic nrzi_select,      // line code select
  input  wire logic tx_invalid_en,    // invalid code enable
  input  wire logic cipher_bypass     // scrambler bypass
);
  // ***************************************************
  // helper logic
  // ***************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [4:0] ctl;
  logic       mdc_q;
  logic [5:0] rises;
  assign ctl = {cmd_override_en, cipher_test_mode, nrzi_select, tx_invalid_en, cipher_bypass};
  // counts mdc rises while the pin is driven
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mdc_q <= 1'b0;
      rises <= 6'h00;
    end else begin
      mdc_q <= mdc;
      if (mdio_oe_n) begin
        rises <= 6'h00;
      end else if (mdc && !mdc_q) begin
        rises <= rises + 6'h01;
      end
    end
  end
  a_reset_values: assert property ($fell(sys_rst) |-> ctl == 5'h04 && mdio_oe_n && mdio_out)
    else $error("outputs wrong after reset");
  a_ctl_on_mdc: assert property ($changed(ctl) |-> $past(mdc, 2))
    else $error("control changed without management clock");
  a_ctl_settled: assert property ($changed(ctl) |=> $stable(ctl) [*8])
    else $error("control changed twice for one write");
  a_ctl_read_hold: assert property (!mdio_oe_n |-> $stable(ctl))
    else $error("control changed during a read");
  a_pin_on_mdc: assert property ($changed({mdio_out, mdio_oe_n}) |-> $past(mdc, 2))
    else $error("data pin moved without management clock");
  a_ta_zero: assert property ($fell(mdio_oe_n) |-> !mdio_out)
    else $error("turnaround bit not zero");
  a_read_len: assert property ($rose(mdio_oe_n) |-> rises == 6'h11)
    else $error("read drive length wrong");
  a_idle_high: assert property (mdio_oe_n && $past(mdio_oe_n, 2) |-> mdio_out)
    else $error("idle data value not one");
endmodule : pecs_regs_checker
`default_nettype wire

// >>> verif/pecs_sta_model.sv
`timescale 1ns/1ns
`default_nettype none
module pecs_sta_model (
  input  wire logic clock,   // system clock
  input  wire logic mdio,    // resolved data line
  output var  logic mdc,     // management clock, still between frames
  output var  logic sta_out, // driven data value
  output var  logic sta_en   // high while driving
);
  // ***************************************************
  // station side of the serial bus
  // ***************************************************
  localparam int HALF = 8;  // wide enough for the two-flop sync inside
  initial begin
    mdc = 1'b0;
    sta_out = 1'b1;
    sta_en = 1'b0;
  end
  task automatic bit_cyc(input logic drv, input logic b, output logic s);
    sta_en = drv;
    sta_out = b;
    repeat (HALF) @(negedge clock);
    s = mdio;
    mdc = 1'b1;
    repeat (HALF) @(negedge clock);
    mdc = 1'b0;
  endtask : bit_cyc
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'b01, op, pa, ra};
    rd = 16'h0000;
    repeat (32) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
    if (op == pecs_pkg::OP_READ) begin
      bit_cyc(1'b0, 1'b1, s);
      bit_cyc(1'b0, 1'b1, s);
      for (int i = 15; i >= 0; i--) begin
        bit_cyc(1'b0, 1'b1, s);
        rd[i] = s;
      end
    end else begin
      bit_cyc(1'b1, 1'b1, s);
      bit_cyc(1'b1, 1'b0, s);
      for (int i = 15; i >= 0; i--) bit_cyc(1'b1, wd[i], s);
    end
    sta_en = 1'b0;
    // one idle clock so the next frame never re-drives in the same step
    @(negedge clock);
  endtask : xfer
endmodule : pecs_sta_model
`default_nettype wire

// >>> verif/pecs_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
module pecs_regs_bench;
  logic        clock = 1'b0, sys_rst = 1'b1, lp_np_load = 1'b0, speed_100 = 1'b0;
  logic        full_duplex = 1'b0;
  logic [3:0]  strap = 4'h0;
  logic [2:0]  prog = 3'h0, hold = 3'h0;
  logic [15:0] np_word = 16'h0000, rd, w;
  wire  logic  mdc, mdio_out, mdio_oe_n, sta_out, sta_en, ovr, ctest, nrzi, txinv, byp;
  wire  logic  mdio = !mdio_oe_n ? mdio_out : sta_en ? sta_out : 1'b1;  // pull-up
  int          num_errors = 0, cmp_count = 0;
  always #4 clock = ~clock;
  pecs_sta_model u_sta (.clock(clock), .mdio(mdio), .mdc(mdc), .sta_out(sta_out),
                        .sta_en(sta_en));
  pecs_regs u_dut (.clock(clock), .sys_rst(sys_rst), .mdc(mdc), .mdio_in(mdio),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phyad_strap(strap), .lp_np_word(np_word),
    .lp_np_load(lp_np_load), .speed_100(speed_100), .full_duplex(full_duplex),
    .an_progress(prog), .cmd_override_en(ovr), .cipher_test_mode(ctest), .nrzi_select(nrzi),
    .tx_invalid_en(txinv), .cipher_bypass(byp));
  // ***************************************************
  // helpers
  // ***************************************************
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic rd_reg(input logic [4:0] ra, output logic [15:0] d);
    u_sta.xfer(pecs_pkg::OP_READ, {1'b1, strap}, ra, 16'h0000, d);
  endtask : rd_reg
  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    u_sta.xfer(pecs_pkg::OP_WRITE, {1'b1, strap}, ra, wd, d);
  endtask : wr_reg
  function automatic logic [15:0] ctl_exp(input logic [15:0] wd);
    ctl_exp = (wd & 16'h802D) | {5'h00, 1'b1, strap, 6'h00};
  endfunction : ctl_exp
  task automatic set_prog(input logic [2:0] v);
    @(negedge clock);
    prog = v;
    {speed_100, full_duplex} = 2'($urandom);
    if (v > hold) hold = v;
    repeat (2) @(negedge clock);
  endtask : set_prog
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  // ***************************************************
  // tests
  // ***************************************************
  initial begin
    #700000;
    num_errors++;
    summarize();
  end
  initial begin
    w = 16'($urandom(32'h4D1A));
    strap = 4'($urandom);
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    check("pins", {11'h0, ovr, ctest, nrzi, txinv, byp}, 16'h0004);
    rd_reg(pecs_pkg::REG_EXT_CTRL, rd);
    check("ctl", rd, ctl_exp(16'h0008));
    rd_reg(pecs_pkg::REG_LP_NP, rd);
    check("np", rd, 16'h0000);
    rd_reg(pecs_pkg::REG_QP_STAT, rd);
    check("qp", rd, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      // reserved bits always written as zero
      w = (i == 0) ? 16'h87ED : (i == 1) ? 16'h0000 : 16'($urandom) & 16'h87ED;
      wr_reg(pecs_pkg::REG_EXT_CTRL, w);
      check("pins", {11'h0, ovr, ctest, nrzi, txinv, byp},
            {11'h0, w[15], w[5], w[3], w[2], w[0]});
      rd_reg(pecs_pkg::REG_EXT_CTRL, rd);
      check("ctl", rd, ctl_exp(w));
    end
    // reset in mid-run with a fresh strap: defaults return, address recaptured
    @(negedge clock);
    sys_rst = 1'b1;
    strap = 4'($urandom);
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    check("pins", {11'h0, ovr, ctest, nrzi, txinv, byp}, 16'h0004);
    rd_reg(pecs_pkg::REG_EXT_CTRL, rd);
    check("ctl", rd, ctl_exp(16'h0008));
    wr_reg(pecs_pkg::REG_EXT_CTRL, 16'h8008);
    check("ovr", {15'h0, ovr}, 16'h0001);
    for (int a = 9; a <= 15; a++) begin
      wr_reg(5'(a), 16'($urandom));
      check("ovr", {15'h0, ovr}, 16'h0000);
      rd_reg(5'(a), rd);
      check("rsv", rd, 16'h0000);
    end
    rd_reg(pecs_pkg::REG_EXT_CTRL, rd);
    check("ctl", rd, ctl_exp(16'h0008));
    // foreign address: nobody answers, line stays at the pull-up
    u_sta.xfer(pecs_pkg::OP_WRITE, {1'b1, ~strap}, pecs_pkg::REG_EXT_CTRL, 16'h0025, rd);
    u_sta.xfer(pecs_pkg::OP_READ, {1'b1, ~strap}, pecs_pkg::REG_EXT_CTRL, 16'h0000, rd);
    check("foreign", rd, 16'hFFFF);
    rd_reg(pecs_pkg::REG_EXT_CTRL, rd);
    check("ctl", rd, ctl_exp(16'h0008));
    for (int i = 0; i < 3; i++) begin
      @(negedge clock);
      np_word = (i == 0) ? 16'hFFFF : 16'($urandom);
      lp_np_load = 1'b1;
      @(negedge clock);
      lp_np_load = 1'b0;
      np_word = ~np_word;
      // read-only: a management write of the inverse must not land
      wr_reg(pecs_pkg::REG_LP_NP, np_word);
      rd_reg(pecs_pkg::REG_LP_NP, rd);
      check("np", rd, ~np_word);
    end
    // status is read-only: an all-ones write must leave no trace
    wr_reg(pecs_pkg::REG_QP_STAT, 16'hFFFF);
    for (int i = 0; i < 5; i++) begin
      set_prog((i == 0) ? 3'h7 : 3'($urandom));
      set_prog((i == 0) ? 3'h0 : 3'($urandom));
      rd_reg(pecs_pkg::REG_QP_STAT, rd);
      check("qp", rd, {speed_100, full_duplex, hold, 11'h000});
      hold = prog;
    end
    summarize();
  end
endmodule : pecs_regs_bench
bind pecs_regs pecs_regs_checker u_chk (.clock(clock), .sys_rst(sys_rst), .mdc(mdc),
  .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .cmd_override_en(cmd_override_en),
  .cipher_test_mode(cipher_test_mode), .nrzi_select(nrzi_select),
  .tx_invalid_en(tx_invalid_en), .cipher_bypass(cipher_bypass));
`default_nettype wire
